/* File: inc/lvd_pkg.sv */
// Functional notes
// - reset mode: below level asserts internal reset
// - interrupt mode: below level raises interrupt
// - mode set while above: no reset
// - interrupt path has no settling delay
// - external reset sets interrupt mask
// - low-voltage reset sets reset cause flag
// - interrupt follows flag only in interrupt mode
// - control bits survive low-voltage reset only
`default_nettype none
package lvd_pkg;
   localparam logic [4:0] OFF_CTRL = 5'h00;
   localparam logic [4:0] OFF_LEVEL = 5'h04;
   localparam logic [4:0] OFF_IRQF = 5'h08;
   localparam logic [4:0] OFF_MASK = 5'h0c;
   localparam logic [4:0] OFF_CAUSE = 5'h10;
   localparam int BIT_COMP_EN = 7;
   localparam int BIT_REF_EN = 4;
   localparam int BIT_RST_MODE = 1;
   localparam int BIT_BELOW = 0;
   localparam int BIT_FLAG = 0;
   localparam int LEVEL_W = 3;
   localparam logic [2:0] LEVEL_RESET = 3'h0;
   localparam logic MASK_RESET = 1'b1;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic comp_en;
      logic ref_en;
      logic rst_mode;
   } ctrl_t;

   typedef struct packed {
      logic ref_on;
      logic cmp_on;
      logic [LEVEL_W-1:0] level;
   } analog_ctl_t;

   localparam ctrl_t CTRL_RESET = '{comp_en: 1'b0, ref_en: 1'b0,
                                    rst_mode: 1'b0};
endpackage : lvd_pkg
`default_nettype wire

/* File: rtl/low_voltage_detect_control.sv */
`timescale 1ns/1ns
`default_nettype none
module low_voltage_detect_control #(
   parameter bit POC_FITTED = 1'b0
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [4:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [4:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic comparator_below,
   output logic lowvolt_reset,
   output logic lowvolt_interrupt,
   output lvd_pkg::analog_ctl_t analog_ctl
);
   function automatic logic is_mapped(input logic [4:0] a);
      is_mapped = (a == lvd_pkg::OFF_CTRL) || (a == lvd_pkg::OFF_LEVEL) ||
                  (a == lvd_pkg::OFF_IRQF) || (a == lvd_pkg::OFF_MASK) ||
                  (a == lvd_pkg::OFF_CAUSE);
   endfunction : is_mapped

   logic below_sync;
   lvd_sync u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .async_in(comparator_below),
      .sync_out(below_sync)
   );

   // bus state
   logic aw_have_reg, aw_have_next;
   logic [4:0] aw_addr_reg, aw_addr_next;
   logic w_have_reg, w_have_next;
   logic [31:0] w_data_reg, w_data_next;
   logic w_lane_reg, w_lane_next;
   logic awready_reg, awready_next;
   logic wready_reg, wready_next;
   logic bvalid_reg, bvalid_next;
   logic [1:0] bresp_reg, bresp_next;
   logic arready_reg, arready_next;
   logic rvalid_reg, rvalid_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [1:0] rresp_reg, rresp_next;
   logic do_write;

   // detector state
   lvd_pkg::ctrl_t ctrl_reg, ctrl_next;
   logic [lvd_pkg::LEVEL_W-1:0] level_reg, level_next;
   logic below_reg, below_next;
   logic mask_reg, mask_next;
   logic req_reg, req_next;
   logic cause_reg, cause_next;
   logic lvrst_reg, lvrst_next;
   logic intr_reg, intr_next;
   lvd_pkg::analog_ctl_t actl_reg, actl_next;

   function automatic logic [31:0] read_mux(input logic [4:0] a,
      input lvd_pkg::ctrl_t c, input logic [2:0] lv, input logic b,
      input logic m, input logic r, input logic k);
      read_mux = 32'h0;
      case (a)
         lvd_pkg::OFF_CTRL: begin
            read_mux[lvd_pkg::BIT_COMP_EN] = c.comp_en;
            read_mux[lvd_pkg::BIT_REF_EN] = c.ref_en;
            read_mux[lvd_pkg::BIT_RST_MODE] = c.rst_mode;
            read_mux[lvd_pkg::BIT_BELOW] = b;
         end
         lvd_pkg::OFF_LEVEL: read_mux[lvd_pkg::LEVEL_W-1:0] = lv;
         lvd_pkg::OFF_IRQF: read_mux[lvd_pkg::BIT_FLAG] = r;
         lvd_pkg::OFF_MASK: read_mux[lvd_pkg::BIT_FLAG] = m;
         lvd_pkg::OFF_CAUSE: read_mux[lvd_pkg::BIT_FLAG] = k;
         default: read_mux = 32'h0;
      endcase
   endfunction : read_mux

   always_comb begin
      aw_have_next = aw_have_reg;
      aw_addr_next = aw_addr_reg;
      w_have_next = w_have_reg;
      w_data_next = w_data_reg;
      w_lane_next = w_lane_reg;
      bvalid_next = bvalid_reg;
      bresp_next = bresp_reg;
      arready_next = arready_reg;
      rvalid_next = rvalid_reg;
      rdata_next = rdata_reg;
      rresp_next = rresp_reg;
      do_write = 1'b0;
      if (awvalid && awready_reg) begin
         aw_have_next = 1'b1;
         aw_addr_next = awaddr;
      end
      if (wvalid && wready_reg) begin
         w_have_next = 1'b1;
         w_data_next = wdata;
         w_lane_next = wstrb[0];
      end
      if (bvalid_reg && bready) begin
         bvalid_next = 1'b0;
      end
      if (aw_have_reg && w_have_reg && !bvalid_reg) begin
         do_write = 1'b1;
         aw_have_next = 1'b0;
         w_have_next = 1'b0;
         bvalid_next = 1'b1;
         bresp_next = is_mapped(aw_addr_reg) ? lvd_pkg::RESP_OKAY
                                             : lvd_pkg::RESP_SLVERR;
      end
      awready_next = !aw_have_next;
      wready_next = !w_have_next;
      if (arvalid && arready_reg) begin
         arready_next = 1'b0;
         rvalid_next = 1'b1;
         rdata_next = read_mux(araddr, ctrl_reg, level_reg, below_reg,
                               mask_reg, req_reg, cause_reg);
         rresp_next = is_mapped(araddr) ? lvd_pkg::RESP_OKAY
                                        : lvd_pkg::RESP_SLVERR;
      end
      if (rvalid_reg && rready) begin
         rvalid_next = 1'b0;
         arready_next = 1'b1;
      end
      // a new read is taken only once no answer is pending
      arready_next = !rvalid_next;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_reg <= 1'b0;
         aw_addr_reg <= 5'h00;
         w_have_reg <= 1'b0;
         w_data_reg <= 32'h0;
         w_lane_reg <= 1'b0;
         awready_reg <= 1'b0;
         wready_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= lvd_pkg::RESP_OKAY;
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0;
         rresp_reg <= lvd_pkg::RESP_OKAY;
      end else begin
         aw_have_reg <= aw_have_next;
         aw_addr_reg <= aw_addr_next;
         w_have_reg <= w_have_next;
         w_data_reg <= w_data_next;
         w_lane_reg <= w_lane_next;
         awready_reg <= awready_next;
         wready_reg <= wready_next;
         bvalid_reg <= bvalid_next;
         bresp_reg <= bresp_next;
         arready_reg <= arready_next;
         rvalid_reg <= rvalid_next;
         rdata_reg <= rdata_next;
         rresp_reg <= rresp_next;
      end
   end

   always_comb begin
      logic wr;
      wr = do_write && w_lane_reg;
      ctrl_next = ctrl_reg;
      level_next = level_reg;
      mask_next = mask_reg;
      req_next = req_reg;
      cause_next = cause_reg;
      if (wr && aw_addr_reg == lvd_pkg::OFF_CTRL) begin
         ctrl_next.comp_en = w_data_reg[lvd_pkg::BIT_COMP_EN];
         ctrl_next.ref_en = w_data_reg[lvd_pkg::BIT_REF_EN];
         ctrl_next.rst_mode = w_data_reg[lvd_pkg::BIT_RST_MODE];
      end
      if (wr && aw_addr_reg == lvd_pkg::OFF_LEVEL) begin
         level_next = w_data_reg[lvd_pkg::LEVEL_W-1:0];
      end
      if (wr && aw_addr_reg == lvd_pkg::OFF_MASK) begin
         mask_next = w_data_reg[lvd_pkg::BIT_FLAG];
      end
      if (wr && aw_addr_reg == lvd_pkg::OFF_IRQF &&
          !w_data_reg[lvd_pkg::BIT_FLAG]) begin
         req_next = 1'b0;
      end
      if (wr && aw_addr_reg == lvd_pkg::OFF_CAUSE &&
          !w_data_reg[lvd_pkg::BIT_FLAG]) begin
         cause_next = 1'b0;
      end
      // a low-voltage reset re-masks the request but keeps ctrl_reg
      if (lvrst_reg) begin
         mask_next = lvd_pkg::MASK_RESET;
         req_next = 1'b0;
      end
      // hardware sets win over software clears
      if (intr_reg) begin
         req_next = 1'b1;
      end
      if (lvrst_reg) begin
         cause_next = 1'b1;
      end
      below_next = ctrl_reg.comp_en && below_sync;
      lvrst_next = ctrl_reg.comp_en && ctrl_reg.rst_mode && below_reg;
      intr_next = ctrl_reg.comp_en && !ctrl_reg.rst_mode && below_reg;
      actl_next.ref_on = ctrl_reg.ref_en || POC_FITTED;
      actl_next.cmp_on = ctrl_reg.comp_en;
      actl_next.level = level_reg;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_reg <= lvd_pkg::CTRL_RESET;
         level_reg <= lvd_pkg::LEVEL_RESET;
         mask_reg <= lvd_pkg::MASK_RESET;
         req_reg <= 1'b0;
         cause_reg <= 1'b0;
         below_reg <= 1'b0;
         lvrst_reg <= 1'b0;
         intr_reg <= 1'b0;
         actl_reg <= '0;
      end else begin
         ctrl_reg <= ctrl_next;
         level_reg <= level_next;
         mask_reg <= mask_next;
         req_reg <= req_next;
         cause_reg <= cause_next;
         below_reg <= below_next;
         lvrst_reg <= lvrst_next;
         intr_reg <= intr_next;
         actl_reg <= actl_next;
      end
   end

   assign awready = awready_reg;
   assign wready = wready_reg;
   assign bvalid = bvalid_reg;
   assign bresp = bresp_reg;
   assign arready = arready_reg;
   assign rvalid = rvalid_reg;
   assign rdata = rdata_reg;
   assign rresp = rresp_reg;
   assign lowvolt_reset = lvrst_reg;
   assign lowvolt_interrupt = intr_reg;
   assign analog_ctl = actl_reg;

   sequence below_held_s;
      (comparator_below && ctrl_reg.comp_en)[*3];
   endsequence

   rst_gen_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (below_reg && ctrl_reg.comp_en && ctrl_reg.rst_mode) |=> lowvolt_reset)
      else $error("reset not raised below level");
   irq_gen_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (below_reg && ctrl_reg.comp_en && !ctrl_reg.rst_mode)
      |=> lowvolt_interrupt ##1 req_reg)
      else $error("interrupt not raised below level");
   no_rst_above_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !below_reg |=> !lowvolt_reset)
      else $error("reset raised while above level");
   req_nodelay_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(ctrl_reg.comp_en) && !ctrl_reg.rst_mode && below_sync
      |=> ##1 lowvolt_interrupt)
      else $error("interrupt delayed after comparator enable");
   mask_reset_a: assert property (@(posedge aclk)
      !aresetn |=> mask_reg && ctrl_reg == lvd_pkg::CTRL_RESET)
      else $error("mask not set by external reset");
   cause_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
      lowvolt_reset |=> cause_reg)
      else $error("reset cause not recorded");
   irq_mode_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (!ctrl_reg.comp_en || ctrl_reg.rst_mode) |=> !lowvolt_interrupt)
      else $error("interrupt outside interrupt mode");
   ctrl_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
      lowvolt_reset && !do_write |=> $stable(ctrl_reg))
      else $error("control lost in low-voltage reset");
   sync_path_a: assert property (@(posedge aclk) disable iff (!aresetn)
      below_held_s |=> below_reg)
      else $error("synchronised flag did not follow comparator");
endmodule : low_voltage_detect_control
`default_nettype wire

/* File: rtl/lvd_sync.sv */
`timescale 1ns/1ns
`default_nettype none
module lvd_sync (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic async_in,
   output logic sync_out
);
   logic meta_reg;
   logic meta_next;
   logic sync_reg;
   logic sync_next;

   always_comb begin
      meta_next = async_in;
      sync_next = meta_reg;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
      end else begin
         meta_reg <= meta_next;
         sync_reg <= sync_next;
      end
   end

   assign sync_out = sync_reg;
endmodule : lvd_sync
`default_nettype wire

/* File: verif/test_low_voltage_detect_control.sv */
`timescale 1ns/1ns
`default_nettype none
module test_low_voltage_detect_control;
   localparam logic [4:0] A_CTL = lvd_pkg::OFF_CTRL;
   localparam logic [4:0] A_LVL = lvd_pkg::OFF_LEVEL;
   localparam logic [4:0] A_IRQ = lvd_pkg::OFF_IRQF;
   localparam logic [4:0] A_MSK = lvd_pkg::OFF_MASK;
   localparam logic [4:0] A_CAU = lvd_pkg::OFF_CAUSE;
   localparam logic [1:0] OK = lvd_pkg::RESP_OKAY;
   localparam logic [1:0] ERR = lvd_pkg::RESP_SLVERR;
   // software waits in 50 ns clock cycles: 2 ms and 0.2 ms
   localparam int REF_WAIT = 40000;
   localparam int CMP_WAIT = 4000;
   localparam int TIMEOUT_CYC = 92000;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [4:0] awaddr = 5'h00;
   logic [4:0] araddr = 5'h00;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic comparator_below = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hf;
   logic awready, wready, bvalid, arready, rvalid;
   logic lowvolt_reset, lowvolt_interrupt;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   lvd_pkg::analog_ctl_t analog_ctl;
   int error_cnt = 0;
   int check_count = 0;
   int cyc = 0;

   always #25 aclk = ~aclk;

   low_voltage_detect_control i_dut (
      .aclk(aclk), .aresetn(aresetn),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .comparator_below(comparator_below), .lowvolt_reset(lowvolt_reset),
      .lowvolt_interrupt(lowvolt_interrupt), .analog_ctl(analog_ctl)
   );

   task automatic stop_test;
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : stop_test

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   // both channels offered together, each released once taken
   task automatic wr(input logic [4:0] a, input logic [31:0] d,
                     input logic [1:0] er);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
      chk({30'h0, bresp}, {30'h0, er});
      // outputs launched at this edge settle before the caller looks
      #1;
   endtask : wr

   task automatic rr(input logic [4:0] a, input logic [31:0] exp,
                     input logic [1:0] er);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rready <= 1'b0;
      chk(rdata, exp);
      chk({30'h0, rresp}, {30'h0, er});
   endtask : rr

   task automatic wt(input int n);
      repeat (n) @(posedge aclk);
      #1;
   endtask : wt

   always @(posedge aclk) begin
      cyc++;
      if (cyc == TIMEOUT_CYC) begin
         error_cnt++;
         stop_test();
      end
   end

   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      rr(A_CTL, 32'h0, OK);
      rr(A_MSK, 32'h1, OK);
      rr(A_CAU, 32'h0, OK);
      rr(5'h14, 32'h0, ERR);
      wr(5'h14, 32'h1, ERR);
      $display("reset values done");
      // interrupt mode start-up in documented order
      wr(A_MSK, 32'h1, OK);
      wr(A_LVL, 32'hff, OK);
      rr(A_LVL, 32'h7, OK);
      wr(A_LVL, 32'h5, OK);
      // a write with byte lane 0 off leaves the level alone
      wstrb <= 4'h0;
      wr(A_LVL, 32'h3, OK);
      wstrb <= 4'hf;
      rr(A_LVL, 32'h5, OK);
      wr(A_CTL, 32'h10, OK);
      chk({27'h0, analog_ctl}, 32'h15);
      // reference is not always on in this build, so the wait stays
      wt(REF_WAIT);
      wr(A_CTL, 32'h90, OK);
      chk({27'h0, analog_ctl}, 32'h1d);
      wt(CMP_WAIT);
      rr(A_CTL, 32'h90, OK);
      wr(A_IRQ, 32'h0, OK);
      wr(A_MSK, 32'h0, OK);
      @(posedge aclk);
      comparator_below <= 1'b1;
      wt(2);
      chk({31'h0, lowvolt_interrupt}, 32'h0);
      wt(4);
      chk({31'h0, lowvolt_interrupt}, 32'h1);
      chk({31'h0, lowvolt_reset}, 32'h0);
      rr(A_CTL, 32'h91, OK);
      rr(A_IRQ, 32'h1, OK);
      @(posedge aclk);
      comparator_below <= 1'b0;
      wt(6);
      chk({31'h0, lowvolt_interrupt}, 32'h0);
      rr(A_CTL, 32'h90, OK);
      wr(A_IRQ, 32'h1, OK);
      rr(A_IRQ, 32'h1, OK);
      wr(A_IRQ, 32'h0, OK);
      rr(A_IRQ, 32'h0, OK);
      // re-enable while the supply is already low and unmasked
      wr(A_CTL, 32'h10, OK);
      @(posedge aclk);
      comparator_below <= 1'b1;
      wt(3);
      wr(A_CTL, 32'h90, OK);
      wt(2);
      chk({31'h0, lowvolt_interrupt}, 32'h1);
      @(posedge aclk);
      comparator_below <= 1'b0;
      wt(6);
      chk({31'h0, lowvolt_interrupt}, 32'h0);
      wr(A_CTL, 32'h0, OK);
      chk({27'h0, analog_ctl}, 32'h05);
      $display("interrupt mode done");
      // reset mode
      wr(A_MSK, 32'h1, OK);
      wr(A_CTL, 32'h10, OK);
      wt(REF_WAIT);
      wr(A_CTL, 32'h90, OK);
      wt(CMP_WAIT);
      rr(A_CTL, 32'h90, OK);
      wr(A_CTL, 32'h92, OK);
      wt(6);
      chk({31'h0, lowvolt_reset}, 32'h0);
      @(posedge aclk);
      comparator_below <= 1'b1;
      wt(6);
      chk({31'h0, lowvolt_reset}, 32'h1);
      chk({31'h0, lowvolt_interrupt}, 32'h0);
      @(posedge aclk);
      comparator_below <= 1'b0;
      // supply settles before software touches the block again
      wt(6);
      chk({31'h0, lowvolt_reset}, 32'h0);
      rr(A_CAU, 32'h1, OK);
      rr(A_CTL, 32'h92, OK);
      rr(A_LVL, 32'h5, OK);
      wr(A_CAU, 32'h0, OK);
      rr(A_CAU, 32'h0, OK);
      wr(A_CTL, 32'h90, OK);
      wr(A_CTL, 32'h10, OK);
      wr(A_CTL, 32'h0, OK);
      chk({27'h0, analog_ctl}, 32'h05);
      $display("reset mode done");
      // external reset in mid-run clears control, re-masks
      wr(A_CTL, 32'h92, OK);
      wr(A_MSK, 32'h0, OK);
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      rr(A_CTL, 32'h0, OK);
      rr(A_MSK, 32'h1, OK);
      rr(A_LVL, {29'h0, lvd_pkg::LEVEL_RESET}, OK);
      $display("external reset done");
      stop_test();
   end
endmodule : test_low_voltage_detect_control
`default_nettype wire
